// >>> mbr_pkg.sv
// Operation
// R01: partitions below their minimum usage get preferential downstream selection
// R02: without maximum limiting, at-or-above-minimum requests compete equally with others
// R03: between minimum and maximum is medium, served when no high waits
// R04: above maximum without hard limit is low, served only when nothing better
// R05: above maximum with hard limit is held until usage drops below maximum
// R06: a high-preference request is delayed only by other high requests
// R07: arbiter may deviate from strict order, e.g. to avoid starvation
// R08: usage resets or decays as the window advances, releasing hard-limited partitions
// R09: unused bandwidth in a window never carries over as credit
// R10: minimum and maximum settings are fixed-point fractions of available bandwidth
// R11: minimum and maximum limiting operate together on the same partitions
// R12: without contention a partition may exceed its maximum unless hard limited
// R13: usage is accounted over a window, sliding or cleared per period
// R14: window width reads back for the partition chosen by partition select
// R15: writing window width sets that partition's accounting window in microseconds
// R16: fixed window expiry restarts each usage count from zero; queue kept
// R17: among equal preference, request priority decides the winner
// R18: moving window adds bytes on service and removes them on ageing out
// R19: decaying usage never drops below zero
// R20: software keeps the sum of minimum settings within available bandwidth
// R21: software reprograms allocations when clock changes alter available bandwidth
// R22: full scale 1.0 is all ones in sixteen bits
// R23: unimplemented low fraction bits are truncated on write and read as zero
// R24: per-partition usage counter grows by granted bytes, compared against thresholds
`default_nettype none

package mbr_pkg;

	// sizes
	localparam int NPART   = 4;
	localparam int PID_W   = 2;
	localparam int NREQ    = 4;
	localparam int REQ_W   = 2;
	localparam int BYTES_W = 8;
	localparam int PRIO_W  = 2;
	localparam int CNT_W   = 32;
	localparam int NSLOT   = 8;
	localparam int SLOT_W  = 3;
	localparam int FRAC_W  = 16;
	localparam int WIN_W   = 16;
	localparam int ADDR_W  = 8;

	// timing: window widths are measured in microseconds of CLK_SYS
	localparam int US_NS      = 1000;
	localparam int CLK_NS     = 20;
	localparam int CYC_PER_US = US_NS / CLK_NS;

	// fixed-point fraction: 1.0 is all ones, only the top byte is kept
	localparam logic [FRAC_W-1:0] FRAC_ONE  = 16'hffff;
	localparam logic [FRAC_W-1:0] FRAC_MASK = 16'hff00;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_PART_SEL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MIN      = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MAX      = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_WINWD    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_AVAIL    = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_USAGE    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1c;

	// field positions
	localparam int MAX_HARD_BIT = 31;
	localparam int WIN_LSB      = 8;
	localparam int MODE_MAXEN   = 2;

	// values after reset
	localparam logic [FRAC_W-1:0] MIN_RST   = 16'h0000;
	localparam logic [FRAC_W-1:0] MAX_RST   = 16'hff00;
	localparam logic [WIN_W-1:0]  WIN_RST   = 16'h000a;
	localparam logic [15:0]       AVAIL_RST = 16'h0190;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ACCT_FIXED, ACCT_MOVING, ACCT_DECAY} mbr_acct_t;
	typedef enum logic [1:0] {PREF_NONE, PREF_LOW, PREF_MED, PREF_HIGH} mbr_pref_t;

	typedef struct packed {
		logic               valid;
		logic [PID_W-1:0]   pid;
		logic [BYTES_W-1:0] bytes;
		logic [PRIO_W-1:0]  prio;
	} mbr_req_t;

	typedef struct packed {
		logic [PID_W-1:0]   pid;
		logic [BYTES_W-1:0] bytes;
	} mbr_ds_t;

endpackage : mbr_pkg

`default_nettype wire

// >>> mbr_win_timer.sv
`default_nettype none

module mbr_win_timer
	import mbr_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIN_W-1:0] win_us,
	output logic                  slot_tick,
	output logic                  win_tick
);
	logic [CNT_W-1:0]  len;
	logic [CNT_W-1:0]  cnt_q;
	logic [SLOT_W-1:0] slot_q;
	logic              wrap;

	// a window is eight equal slots; zero width is treated as the shortest slot
	assign len       = (CNT_W'(win_us) * CNT_W'(CYC_PER_US)) >> SLOT_W;
	assign wrap      = (cnt_q + 32'h1 >= len);
	assign slot_tick = wrap;
	assign win_tick  = wrap && (slot_q == {SLOT_W{1'b1}});

	// R13 window period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q  <= '0;
			slot_q <= '0;
		end else if (wrap) begin
			cnt_q  <= '0;
			slot_q <= slot_q + 3'h1;
		end else begin
			cnt_q  <= cnt_q + 32'h1;
		end
	end

	a_win_on_slot: assert property (@(posedge clk) disable iff (rst) // R13
		win_tick |=> slot_q == 3'h0 && cnt_q == 32'h0)
		else $error("window did not restart its slots");

endmodule : mbr_win_timer

`default_nettype wire

// >>> mbr_usage.sv
`default_nettype none

module mbr_usage
	import mbr_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire mbr_acct_t          mode,
	input  wire logic               slot_tick,
	input  wire logic               win_tick,
	input  wire logic               add_en,
	input  wire logic [BYTES_W-1:0] add_bytes,
	input  wire logic [CNT_W-1:0]   decay_amt,
	output logic      [CNT_W-1:0]   usage
);
	logic [CNT_W-1:0]  slot_q [NSLOT];
	logic [SLOT_W-1:0] idx_q;
	logic [SLOT_W-1:0] idx_d;
	logic [CNT_W-1:0]  usage_q;
	logic [CNT_W-1:0]  add;
	logic [CNT_W-1:0]  aged;
	logic [CNT_W-1:0]  decayed;
	logic [CNT_W-1:0]  moved;
	logic [CNT_W-1:0]  usage_d;

	assign add   = add_en ? CNT_W'(add_bytes) : '0;
	assign idx_d = slot_tick ? idx_q + 3'h1 : idx_q;
	// R18 oldest slot leaves the history
	assign aged  = slot_tick ? slot_q[idx_d] : '0;
	// R19 decay saturates at zero
	assign decayed = (usage_q > decay_amt) ? usage_q - decay_amt : '0;
	// R18 a mode change can leave count and history out of step: never wrap below zero
	assign moved   = (usage_q > aged) ? usage_q - aged + add : add;
	// R08 R09 R16 nothing left over is kept as credit
	assign usage_d = (mode == ACCT_FIXED)  ? (win_tick ? add : usage_q + add) :
	                 (mode == ACCT_MOVING) ? moved :
	                 (slot_tick ? decayed + add : usage_q + add);
	assign usage   = usage_q;

	// R24 usage counter and slot history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			usage_q <= '0;
			idx_q   <= '0;
			for (int i = 0; i < NSLOT; i++) begin
				slot_q[i] <= '0;
			end
		end else begin
			usage_q       <= usage_d;
			idx_q         <= idx_d;
			slot_q[idx_d] <= (slot_tick ? '0 : slot_q[idx_d]) + add;
		end
	end

	a_fixed_restart: assert property (@(posedge clk) disable iff (rst) // R16
		mode == ACCT_FIXED && win_tick && !add_en |=> usage_q == 32'h0)
		else $error("fixed window did not restart usage");

	a_moving_keeps: assert property (@(posedge clk) disable iff (rst) // R18
		mode == ACCT_MOVING && !slot_tick && add_en && $stable(mode)
		|=> usage_q == $past(usage_q) + CNT_W'($past(add_bytes)))
		else $error("moving window lost bytes");

endmodule : mbr_usage

`default_nettype wire

// >>> mbr_regulator.sv
// Chosen here: the register addresses and register access over AXI4-Lite.
`default_nettype none

module mbr_regulator
	import mbr_pkg::*;
(
	input  wire logic                 CLK_SYS,
	input  wire logic                 RESET,
	input  wire logic [ADDR_W-1:0]    S_AXI_AWADDR,
	input  wire logic                 S_AXI_AWVALID,
	output logic                      S_AXI_AWREADY,
	input  wire logic [31:0]          S_AXI_WDATA,
	input  wire logic [3:0]           S_AXI_WSTRB,
	input  wire logic                 S_AXI_WVALID,
	output logic                      S_AXI_WREADY,
	output logic [1:0]                S_AXI_BRESP,
	output logic                      S_AXI_BVALID,
	input  wire logic                 S_AXI_BREADY,
	input  wire logic [ADDR_W-1:0]    S_AXI_ARADDR,
	input  wire logic                 S_AXI_ARVALID,
	output logic                      S_AXI_ARREADY,
	output logic [31:0]               S_AXI_RDATA,
	output logic [1:0]                S_AXI_RRESP,
	output logic                      S_AXI_RVALID,
	input  wire logic                 S_AXI_RREADY,
	input  wire mbr_req_t [NREQ-1:0]  REQ,
	output logic [NREQ-1:0]           REQ_GNT,
	output logic                      DS_VALID,
	output logic [PID_W-1:0]          DS_PID,
	output logic [BYTES_W-1:0]        DS_BYTES,
	input  wire logic                 DS_READY
);

	////////////////////////////////////////////////////////////////////////////
	// configuration state

	logic [PID_W-1:0]   sel_q;
	logic [FRAC_W-1:0]  min_q    [NPART];
	logic [FRAC_W-1:0]  max_q    [NPART];
	logic               hard_q   [NPART];
	logic [WIN_W-1:0]   win_q    [NPART];
	mbr_acct_t          mode_q;
	logic               maxen_q;
	logic [15:0]        avail_q;

	// bus handshake state
	logic               awready_q;
	logic               wready_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;
	logic [ADDR_W-1:0]  awaddr_q;
	logic [31:0]        wdata_q;
	logic [3:0]         wstrb_q;
	logic               arready_q;
	logic               rvalid_q;
	logic [31:0]        rdata_q;
	logic [1:0]         rresp_q;

	// arbitration state
	logic [REQ_W-1:0]   rr_q;
	logic [NREQ-1:0]    gnt_q;
	logic               dsv_q;
	mbr_ds_t            ds_q;

	////////////////////////////////////////////////////////////////////////////
	// per-partition accounting

	logic [CNT_W-1:0]   usage    [NPART];
	logic [CNT_W-1:0]   min_thr  [NPART];
	logic [CNT_W-1:0]   max_thr  [NPART];
	mbr_pref_t          part_pref[NPART];
	logic               take;
	logic [REQ_W-1:0]   win_idx;
	mbr_req_t           win_req;

	for (genvar p = 0; p < NPART; p++) begin : g_part
		logic [31:0] bw_win;
		logic [47:0] min_prod;
		logic [47:0] max_prod;
		logic        slot_tick;
		logic        win_tick;
		logic        add_en;

		// R10 R22 threshold is fraction times the bytes a window can carry
		assign bw_win     = 32'(avail_q) * 32'(win_q[p]);
		assign min_prod   = 48'(bw_win) * 48'(min_q[p]);
		assign max_prod   = 48'(bw_win) * 48'(max_q[p]);
		assign min_thr[p] = min_prod[47:16];
		assign max_thr[p] = max_prod[47:16];
		assign add_en     = take && (win_req.pid == PID_W'(p));

		// R15 each partition runs on its own window width
		mbr_win_timer u_timer (
			.clk       (CLK_SYS),
			.rst       (RESET),
			.win_us    (win_q[p]),
			.slot_tick (slot_tick),
			.win_tick  (win_tick)
		);

		// R24 granted bytes are counted per partition
		mbr_usage u_usage (
			.clk       (CLK_SYS),
			.rst       (RESET),
			.mode      (mode_q),
			.slot_tick (slot_tick),
			.win_tick  (win_tick),
			.add_en    (add_en),
			.add_bytes (win_req.bytes),
			.decay_amt (max_thr[p] >> SLOT_W),
			.usage     (usage[p])
		);

		// R01 R03 R04 R05 R11 classify by usage against both limits
		// R02 with maximum limiting off, everything above minimum is one class
		assign part_pref[p] = (usage[p] < min_thr[p])                ? PREF_HIGH :
		                      (!maxen_q || usage[p] < max_thr[p])    ? PREF_MED  :
		                      hard_q[p]                              ? PREF_NONE :
		                                                               PREF_LOW;
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration

	logic [NREQ-1:0]    elig;
	mbr_pref_t          req_pref [NREQ];
	logic [NREQ-1:0]    is_high;
	logic [NREQ-1:0]    is_med;
	logic               any_high;
	logic               any_med;
	logic               found;
	logic               slot_free;

	for (genvar r = 0; r < NREQ; r++) begin : g_req
		assign req_pref[r] = part_pref[REQ[r].pid];
		// R05 hard-limited requests are simply not eligible; a fresh grant is masked
		assign elig[r]     = REQ[r].valid && !gnt_q[r] && req_pref[r] != PREF_NONE;
		assign is_high[r]  = elig[r] && req_pref[r] == PREF_HIGH;
		assign is_med[r]   = elig[r] && req_pref[r] == PREF_MED;
	end

	assign any_high  = |is_high;
	assign any_med   = |is_med;
	assign slot_free = !dsv_q || DS_READY;

	// R06 R17 pick highest preference, then priority, ties from the rotating start
	// R07 the rotating start keeps equal requests from starving
	always_comb begin
		logic [REQ_W-1:0]        i;
		logic [1+PRIO_W:0]       sc;
		logic [1+PRIO_W:0]       best;
		i       = '0;
		sc      = '0;
		found   = 1'b0;
		win_idx = '0;
		best    = '0;
		for (int k = 0; k < NREQ; k++) begin
			i  = rr_q + REQ_W'(k);
			sc = {req_pref[i], REQ[i].prio};
			if (elig[i] && (!found || sc > best)) begin
				found   = 1'b1;
				win_idx = i;
				best    = sc;
			end
		end
	end

	// R12 a lone low request is still served: no cap without hard limit
	assign take    = found && slot_free;
	assign win_req = REQ[win_idx];

	// downstream holding stage and grant pulse
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			dsv_q <= 1'b0;
			ds_q  <= '0;
			gnt_q <= '0;
			rr_q  <= '0;
		end else begin
			gnt_q <= take ? NREQ'(1) << win_idx : '0;
			if (take) begin
				dsv_q <= 1'b1;
				ds_q  <= '{pid: win_req.pid, bytes: win_req.bytes};
				rr_q  <= win_idx + 2'h1;
			end else if (DS_READY) begin
				dsv_q <= 1'b0;
			end
		end
	end

	assign REQ_GNT  = gnt_q;
	assign DS_VALID = dsv_q;
	assign DS_PID   = ds_q.pid;
	assign DS_BYTES = ds_q.bytes;

	a_no_hard_grant: assert property (@(posedge CLK_SYS) disable iff (RESET) // R05
		take |-> part_pref[win_req.pid] != PREF_NONE)
		else $error("hard-limited partition was granted");

	a_high_first: assert property (@(posedge CLK_SYS) disable iff (RESET) // R06
		take && any_high |-> part_pref[win_req.pid] == PREF_HIGH)
		else $error("high request passed over");

	a_med_over_low: assert property (@(posedge CLK_SYS) disable iff (RESET) // R04
		take && !any_high && any_med |-> part_pref[win_req.pid] == PREF_MED)
		else $error("low request beat a medium one");

	a_grant_to_ds: assert property (@(posedge CLK_SYS) disable iff (RESET) // R24
		take |=> DS_VALID && DS_PID == $past(win_req.pid) && REQ_GNT[$past(win_idx)])
		else $error("grant did not reach downstream");

	a_ds_hold: assert property (@(posedge CLK_SYS) disable iff (RESET) // R17
		DS_VALID && !DS_READY |=> DS_VALID && $stable(DS_PID) && $stable(DS_BYTES))
		else $error("downstream beat changed while stalled");

	////////////////////////////////////////////////////////////////////////////
	// register decode

	logic        do_write;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] old_word;
	logic [31:0] new_word;
	logic [31:0] rd_word;
	logic [31:0] status_word;

	assign do_write = !awready_q && !wready_q && !bvalid_q;
	assign wr_ok    = awaddr_q == OFS_PART_SEL || awaddr_q == OFS_MIN ||
	                  awaddr_q == OFS_MAX || awaddr_q == OFS_WINWD ||
	                  awaddr_q == OFS_MODE || awaddr_q == OFS_AVAIL ||
	                  awaddr_q == OFS_USAGE || awaddr_q == OFS_STATUS;
	assign rd_ok    = S_AXI_ARADDR == OFS_PART_SEL || S_AXI_ARADDR == OFS_MIN ||
	                  S_AXI_ARADDR == OFS_MAX || S_AXI_ARADDR == OFS_WINWD ||
	                  S_AXI_ARADDR == OFS_MODE || S_AXI_ARADDR == OFS_AVAIL ||
	                  S_AXI_ARADDR == OFS_USAGE || S_AXI_ARADDR == OFS_STATUS;

	// status shows each partition's current preference class
	for (genvar s = 0; s < NPART; s++) begin : g_stat
		assign status_word[2*s +: 2] = part_pref[s];
	end
	assign status_word[31:2*NPART] = '0;

	// R14 R23 per-partition fields read for the selected partition
	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a,
	                                       input logic [PID_W-1:0]  p);
		logic [31:0] v;
		v = 32'h0;
		if (a == OFS_PART_SEL) v = 32'(sel_q);
		if (a == OFS_MIN)      v = 32'(min_q[p]);
		if (a == OFS_MAX)      v = {hard_q[p], 15'h0, max_q[p]};
		if (a == OFS_WINWD)    v = 32'(win_q[p]) << WIN_LSB;
		if (a == OFS_MODE)     v = {29'h0, maxen_q, mode_q};
		if (a == OFS_AVAIL)    v = 32'(avail_q);
		if (a == OFS_USAGE)    v = usage[p];
		if (a == OFS_STATUS)   v = status_word;
		return v;
	endfunction : rd_mux

	assign old_word = rd_mux(awaddr_q, sel_q);
	assign rd_word  = rd_mux(S_AXI_ARADDR, sel_q);

	// byte lanes not strobed keep their old contents
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign new_word[8*b +: 8] = wstrb_q[b] ? wdata_q[8*b +: 8] : old_word[8*b +: 8];
	end

	////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order, answer after both

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
		end else begin
			if (S_AXI_AWVALID && awready_q) begin
				awready_q <= 1'b0;
				awaddr_q  <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && wready_q) begin
				wready_q <= 1'b0;
				wdata_q  <= S_AXI_WDATA;
				wstrb_q  <= S_AXI_WSTRB;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && S_AXI_BREADY) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	// register updates; usage and status are read only
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			sel_q   <= '0;
			mode_q  <= ACCT_FIXED;
			maxen_q <= 1'b1;
			avail_q <= AVAIL_RST;
			for (int p = 0; p < NPART; p++) begin
				min_q[p]  <= MIN_RST;
				max_q[p]  <= MAX_RST;
				hard_q[p] <= 1'b0;
				win_q[p]  <= WIN_RST;
			end
		end else if (do_write) begin
			if (awaddr_q == OFS_PART_SEL) sel_q <= new_word[PID_W-1:0];
			// R23 low fraction bits are dropped on write
			if (awaddr_q == OFS_MIN) min_q[sel_q] <= new_word[FRAC_W-1:0] & FRAC_MASK;
			if (awaddr_q == OFS_MAX) begin
				max_q[sel_q]  <= new_word[FRAC_W-1:0] & FRAC_MASK;
				hard_q[sel_q] <= new_word[MAX_HARD_BIT];
			end
			// R15 integer microseconds; fraction bits unimplemented
			if (awaddr_q == OFS_WINWD) win_q[sel_q] <= new_word[WIN_LSB +: WIN_W];
			if (awaddr_q == OFS_MODE) begin
				mode_q  <= (new_word[1:0] == 2'h3) ? ACCT_FIXED : mbr_acct_t'(new_word[1:0]);
				maxen_q <= new_word[MODE_MAXEN];
			end
			if (awaddr_q == OFS_AVAIL) avail_q <= new_word[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel: data one cycle after the address is taken

	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else if (S_AXI_ARVALID && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_ok ? rd_word : 32'h0;
			rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && S_AXI_RREADY) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY  = wready_q;
	assign S_AXI_BVALID  = bvalid_q;
	assign S_AXI_BRESP   = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID  = rvalid_q;
	assign S_AXI_RDATA   = rdata_q;
	assign S_AXI_RRESP   = rresp_q;

	a_min_trunc: assert property (@(posedge CLK_SYS) disable iff (RESET) // R23
		do_write && awaddr_q == OFS_MIN |=> min_q[$past(sel_q)][7:0] == 8'h0)
		else $error("low fraction bits were stored");

	a_resp_hold: assert property (@(posedge CLK_SYS) disable iff (RESET) // R14
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer changed before taken");

endmodule : mbr_regulator

`default_nettype wire

// >>> mbr_ds_model.sv
`default_nettype none

module mbr_ds_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	input  wire logic ds_valid,
	output logic      ds_ready
);
	// downstream channel: ready every cycle, or every other cycle when slow
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ds_ready <= 1'b1;
		end else begin
			ds_ready <= (slow && ds_valid) ? !ds_ready : 1'b1;
		end
	end
endmodule : mbr_ds_model

`default_nettype wire

// >>> mbr_regulator_tb.sv
`default_nettype none

module mbr_regulator_tb
	import mbr_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic                clk_sys = 1'b0;
	logic                rst     = 1'b1;
	logic [ADDR_W-1:0]   awaddr  = '0;
	logic [ADDR_W-1:0]   araddr  = '0;
	logic [31:0]         wdata   = '0;
	logic [31:0]         rdata;
	logic [1:0]          bresp;
	logic [1:0]          rresp;
	logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
	logic                awready, wready, bvalid, arready, rvalid;
	mbr_req_t [NREQ-1:0] req     = '0;
	logic [NREQ-1:0]     gnt;
	logic                ds_valid, ds_ready;
	logic [PID_W-1:0]    ds_pid;
	logic [BYTES_W-1:0]  ds_bytes;
	int                  error_cnt = 0;
	int                  samples_checked = 0;

	always #10 clk_sys = ~clk_sys;

	mbr_regulator i_dut (.CLK_SYS(clk_sys), .RESET(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .REQ(req), .REQ_GNT(gnt), .DS_VALID(ds_valid),
		.DS_PID(ds_pid), .DS_BYTES(ds_bytes), .DS_READY(ds_ready));

	mbr_ds_model i_ds (.clk(clk_sys), .rst(rst), .slow(slow), .ds_valid(ds_valid),
		.ds_ready(ds_ready));

	////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w  = 1'b1;
		@(posedge clk_sys);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (aw || w) begin
			@(posedge clk_sys);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (!bvalid);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
	endtask : wr

	task automatic rck(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk_sys);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		do @(posedge clk_sys); while (!rvalid);
		rready <= 1'b0;
		chk(rdata, e);
		chk(32'(rresp), 32'(er));
	endtask : rck

	task automatic put(input int r, input logic [1:0] p, input logic [1:0] q);
		req[r] <= '{1'b1, p, 8'h08, q};
	endtask : put

	// waits for the next grant, retires the granted requester and checks the winner
	task automatic next_gnt(input logic [3:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (gnt == 4'h0 && n < 200);
		for (int i = 0; i < NREQ; i++) if (gnt[i]) req[i].valid <= 1'b0;
		chk(32'(gnt), 32'(exp));
	endtask : next_gnt

	task automatic count_gnt(output int n);
		n = 0;
		repeat (480) begin
			@(posedge clk_sys);
			if (gnt[0] === 1'b1) n++;
		end
		req[0].valid <= 1'b0;
	endtask : count_gnt

	////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk(32'({gnt, ds_valid}), 32'h0);
		rck(OFS_MAX, 32'h0000ff00, RESP_OKAY);
		rck(OFS_WINWD, 32'h00000a00, RESP_OKAY);
		rck(OFS_MODE, 32'h4, RESP_OKAY);
		rck(OFS_AVAIL, 32'h190, RESP_OKAY);
		rck(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h1, RESP_SLVERR);
	endtask : t_reset

	// pid1 gets nearly the whole bandwidth as its minimum, the sum stays within 1.0
	task automatic t_frac();
		wr(OFS_PART_SEL, 32'h1, RESP_OKAY);
		wr(OFS_MIN, 32'h07ae, RESP_OKAY);
		rck(OFS_MIN, 32'h0700, RESP_OKAY);
		wr(OFS_MIN, 32'hffff, RESP_OKAY);
		rck(OFS_MIN, 32'hff00, RESP_OKAY);
		// a clock change halves the downstream rate; software rewrites it, then restores it
		wr(OFS_AVAIL, 32'hc8, RESP_OKAY);
		rck(OFS_AVAIL, 32'hc8, RESP_OKAY);
		wr(OFS_AVAIL, 32'h190, RESP_OKAY);
	endtask : t_frac

	// pid1 high, pid0 and pid2 medium, pid3 low; pid1, pid0, pid3 granted in that order under a stalling sink
	task automatic t_classes();
		wr(OFS_PART_SEL, 32'h3, RESP_OKAY);
		wr(OFS_MAX, 32'h0, RESP_OKAY);
		rck(OFS_STATUS, 32'h6e, RESP_OKAY);
		@(posedge clk_sys);
		slow <= 1'b1;
		put(0, 2'h3, 2'h3);
		put(1, 2'h0, 2'h0);
		put(2, 2'h1, 2'h0);
		next_gnt(4'b0100);
		chk(32'({ds_valid, ds_pid, ds_bytes}), 32'h508);
		next_gnt(4'b0010);
		next_gnt(4'b0001);
		slow <= 1'b0;
	endtask : t_classes

	task automatic t_prio();
		@(posedge clk_sys);
		put(0, 2'h0, 2'h1);
		put(1, 2'h0, 2'h3);
		next_gnt(4'b0010);
		next_gnt(4'b0001);
		@(posedge clk_sys);
		put(0, 2'h0, 2'h3);
		put(1, 2'h0, 2'h1);
		next_gnt(4'b0001);
		next_gnt(4'b0010);
	endtask : t_prio

	// with maximum limiting off the low partition competes on priority alone
	task automatic t_nomax();
		wr(OFS_MODE, 32'h0, RESP_OKAY);
		@(posedge clk_sys);
		put(0, 2'h3, 2'h3);
		put(1, 2'h0, 2'h0);
		next_gnt(4'b0001);
		next_gnt(4'b0010);
		wr(OFS_MODE, 32'h4, RESP_OKAY);
	endtask : t_nomax

	// 1 us window (48 cycles), max threshold 25 bytes: about four 8-byte grants per window
	task automatic t_hard();
		int n;
		wr(OFS_PART_SEL, 32'h2, RESP_OKAY);
		wr(OFS_WINWD, 32'h100, RESP_OKAY);
		rck(OFS_WINWD, 32'h100, RESP_OKAY);
		wr(OFS_MAX, 32'h80001000, RESP_OKAY);
		for (int m = 0; m < 3; m++) begin
			wr(OFS_MODE, 32'(4 + m), RESP_OKAY);
			@(posedge clk_sys);
			put(0, 2'h2, 2'h0);
			count_gnt(n);
			chk(32'(n >= 25 && n <= 52), 32'h1);
		end
		wr(OFS_MAX, 32'h00001000, RESP_OKAY);
		wr(OFS_MODE, 32'h4, RESP_OKAY);
		@(posedge clk_sys);
		put(0, 2'h2, 2'h0);
		count_gnt(n);
		chk(32'(n > 100), 32'h1);
	endtask : t_hard

	////////////////////////////////////////////////////////////////////////////
	// verdict and run control
	task automatic conclude();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude

	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_frac();
		t_classes();
		t_prio();
		t_nomax();
		t_hard();
		conclude();
	end

	// watchdog: the whole sequence needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		conclude();
	end
endmodule : mbr_regulator_tb

`default_nettype wire
